// File: rtl/ccp_top.sv
`default_nettype none
module ccp_top (
  input wire logic pclk, // APB clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic irq, // Interrupt, active high level
  input wire logic clock_select_in, // Clock selector output, pclk domain
  input wire logic supply_ok_in, // Card supply good, async pin
  output logic card_supply_en, // Card supply converter enable
  output logic card_clock_out, // Card clock
  output logic card_clock_slope_fast, // Card clock slope select
  input wire logic card_presence_in, // Card detect pin
  output logic card_presence_pullup_en, // Weak pull-up enable
  input wire logic host_reset_in, // Host reset, async pin
  input wire logic chip_select_n, // Chip select, active low, async pin
  output logic card_reset_out, // Card reset
  input wire logic host_io_in, // Host data line level
  output logic host_io_out, // Host data line drive value
  output logic host_io_oe, // Host data line drive enable
  input wire logic card_serial_line_in, // Card serial line level
  output logic card_serial_line_out, // Card serial line drive value
  output logic card_serial_line_oe // Card serial line drive enable
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  ////////////////////////////////////////////////////////////////////////
  logic [4:0] pins_sync;
  logic presence_sync;
  logic supply_ok;
  logic host_reset;
  logic cs_n;
  logic host_io_s;
  logic card_io_s;
  logic pres_filt;

  ccp_sync #(.WIDTH(6), .INIT(6'h3f)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({card_presence_in, supply_ok_in, host_reset_in, chip_select_n,
        host_io_in, card_serial_line_in}),
    .q({presence_sync, pins_sync})
  );
  assign supply_ok = pins_sync[4];
  assign host_reset = pins_sync[3];
  assign cs_n = pins_sync[2];
  assign host_io_s = pins_sync[1];
  assign card_io_s = pins_sync[0];

  ccp_filter #(.CYCLES(ccp_pkg::DEBOUNCE_CYC), .INIT(1'b1)) u_filt (
    .pclk(pclk),
    .presetn(presetn),
    .d(presence_sync),
    .q(pres_filt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register file
  ////////////////////////////////////////////////////////////////////////
  logic [ccp_pkg::CTRL_W-1:0] ctrl;
  logic [ccp_pkg::IRQ_W-1:0] irq_stat;
  logic [ccp_pkg::IRQ_W-1:0] irq_mask;
  logic [ccp_pkg::IRQ_W-1:0] irq_set;
  logic [4:0] status_word;

  wire setup_ph = psel && !penable;
  wire access_ph = psel && penable;
  wire hit_ctrl = (paddr == ccp_pkg::ADDR_CTRL);
  wire hit_status = (paddr == ccp_pkg::ADDR_STATUS);
  wire hit_istat = (paddr == ccp_pkg::ADDR_IRQ_STAT);
  wire hit_imask = (paddr == ccp_pkg::ADDR_IRQ_MASK);
  wire hit_any = hit_ctrl || hit_status || hit_istat || hit_imask;
  wire wr_en = access_ph && pwrite && hit_any;
  wire wr_ctrl = wr_en && hit_ctrl;
  wire wr_istat = wr_en && hit_istat;
  wire wr_imask = wr_en && hit_imask;
  wire [ccp_pkg::IRQ_W-1:0] irq_clr =
    wr_istat ? pwdata[ccp_pkg::IRQ_W-1:0] : '0;

  // Zero wait states; read data is latched in the setup cycle
  assign pready = 1'b1;
  assign pslverr = access_ph && !hit_any;

  // Read multiplexer, unmapped reads give zero
  wire [31:0] rd_mux =
    hit_ctrl ? {28'h0000000, ctrl} :
    hit_status ? {27'h0000000, status_word} :
    hit_istat ? {28'h0000000, irq_stat} :
    hit_imask ? {28'h0000000, irq_mask} : 32'h00000000;

  // Read data capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_ph && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // Control and mask registers
  // slope select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ccp_pkg::CTRL_RESET;
      irq_mask <= ccp_pkg::IRQ_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= pwdata[ccp_pkg::CTRL_W-1:0];
      end
      if (wr_imask) begin
        irq_mask <= pwdata[ccp_pkg::IRQ_W-1:0];
      end
    end
  end

  // Sticky events; a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= ccp_pkg::IRQ_RESET;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
    end
  end

  // Level interrupt from unmasked sticky bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_stat & ~irq_clr | irq_set) & irq_mask);
    end
  end

  wire activate = ctrl[ccp_pkg::CTRL_ACTIVATE];
  wire slope_fast = ctrl[ccp_pkg::CTRL_SLOPE_FAST];
  wire pres_high = ctrl[ccp_pkg::CTRL_PRES_HIGH];
  wire special = ctrl[ccp_pkg::CTRL_SPECIAL];

  ////////////////////////////////////////////////////////////////////////
  // Card power sequence
  ////////////////////////////////////////////////////////////////////////
  localparam int SW = $clog2(ccp_pkg::SETTLE_CYC + 1);
  localparam logic [SW-1:0] SETTLE_LAST = SW'(ccp_pkg::SETTLE_CYC - 1);
  ccp_pkg::ccp_pwr_e pwr;
  ccp_pkg::ccp_pwr_e next_pwr;
  logic [SW-1:0] settle_cnt;
  logic [SW-1:0] next_settle_cnt;
  logic fault;

  // Supply stays off until activated; loss of supply aborts at once
  always_comb begin
    next_pwr = pwr;
    next_settle_cnt = '0;
    fault = 1'b0;
    case (pwr)
      ccp_pkg::CCP_OFF: begin
        if (activate) begin
          next_pwr = ccp_pkg::CCP_RAMP;
        end
      end
      ccp_pkg::CCP_RAMP: begin
        if (!activate) begin
          next_pwr = ccp_pkg::CCP_OFF;
        end else if (supply_ok) begin
          next_pwr = ccp_pkg::CCP_SETTLE;
        end
      end
      ccp_pkg::CCP_SETTLE: begin
        next_settle_cnt = settle_cnt + 1'b1;
        if (!activate || !supply_ok) begin
          next_pwr = ccp_pkg::CCP_OFF;
          fault = activate;
        end else if (settle_cnt == SETTLE_LAST) begin
          next_pwr = ccp_pkg::CCP_ON;
        end
      end
      ccp_pkg::CCP_ON: begin
        if (!activate || !supply_ok) begin
          next_pwr = ccp_pkg::CCP_OFF;
          fault = activate;
        end
      end
      default: begin
        next_pwr = ccp_pkg::CCP_OFF;
      end
    endcase
  end

  // Power state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr <= ccp_pkg::CCP_OFF;
      settle_cnt <= '0;
    end else begin
      pwr <= next_pwr;
      settle_cnt <= next_settle_cnt;
    end
  end

  wire powered = (pwr == ccp_pkg::CCP_ON);
  wire powered_next = (next_pwr == ccp_pkg::CCP_ON);

  // Supply enable requested for every state but off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_supply_en <= 1'b0;
    end else begin
      card_supply_en <= (next_pwr != ccp_pkg::CCP_OFF);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Card clock
  ////////////////////////////////////////////////////////////////////////
  // clock forced low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_clock_out <= 1'b0;
      card_clock_slope_fast <= 1'b0;
    end else begin
      card_clock_out <= powered_next && clock_select_in;
      card_clock_slope_fast <= slope_fast;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Card presence
  ////////////////////////////////////////////////////////////////////////
  // weak pull-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_presence_pullup_en <= 1'b1;
    end else begin
      card_presence_pullup_en <= 1'b1;
    end
  end

  wire inserted = pres_high ? pres_filt : !pres_filt;
  wire presence_status_bit = special ? pres_filt : inserted;
  logic inserted_d;
  logic powered_d;

  // Edge history for event detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inserted_d <= 1'b0;
      powered_d <= 1'b0;
    end else begin
      inserted_d <= inserted;
      powered_d <= powered;
    end
  end

  assign irq_set[ccp_pkg::IRQ_INSERT] = inserted && !inserted_d;
  assign irq_set[ccp_pkg::IRQ_REMOVE] = !inserted && inserted_d;
  assign irq_set[ccp_pkg::IRQ_POWERED] = powered && !powered_d;
  assign irq_set[ccp_pkg::IRQ_FAULT] = fault;

  ////////////////////////////////////////////////////////////////////////
  // Card reset
  ////////////////////////////////////////////////////////////////////////
  // host reset forwarded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_reset_out <= 1'b0;
    end else if (!powered_next) begin
      card_reset_out <= 1'b0;
    end else if (!cs_n) begin
      card_reset_out <= host_reset;
    end
  end

  assign status_word = {supply_ok, card_reset_out, pres_filt, powered,
                        presence_status_bit};

  ////////////////////////////////////////////////////////////////////////
  // Serial line translator
  ////////////////////////////////////////////////////////////////////////
  // Whichever side pulls low first owns the transfer until both lines read high again,
  // which stops the two pull-downs latching each other low.
  logic host_owns;
  logic card_owns;
  logic [1:0] io_arm;

  // Ownership waits until the released card line has passed the sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_arm <= 2'b00;
    end else begin
      io_arm <= powered ? {io_arm[0], 1'b1} : 2'b00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_owns <= 1'b0;
      card_owns <= 1'b0;
    end else if (!io_arm[1]) begin
      host_owns <= 1'b0;
      card_owns <= 1'b0;
    end else begin
      // Owner holds until both lines read high, so its echo is ignored
      host_owns <= host_owns ? (!host_io_s || !card_io_s)
                             : (!card_owns && !host_io_s);
      card_owns <= card_owns ? (!card_io_s || !host_io_s)
                             : (!host_owns && host_io_s && !card_io_s);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_serial_line_oe <= 1'b1;
      host_io_oe <= 1'b0;
    end else begin
      card_serial_line_oe <= !powered_next || (host_owns && !host_io_s);
      host_io_oe <= powered_next && card_owns && !card_io_s;
    end
  end

  // Drive value is always low; release lets the pull-up raise the line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_serial_line_out <= 1'b0;
      host_io_out <= 1'b0;
    end else begin
      card_serial_line_out <= 1'b0;
      host_io_out <= 1'b0;
    end
  end
endmodule : ccp_top
`default_nettype wire

// File: rtl/ccp_pkg.sv
`default_nettype none
package ccp_pkg;
  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;

  // Control register fields
  localparam int CTRL_ACTIVATE = 0;
  localparam int CTRL_SLOPE_FAST = 1;
  localparam int CTRL_PRES_HIGH = 2;
  localparam int CTRL_SPECIAL = 3;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Status register fields
  localparam int ST_PRESENCE = 0;
  localparam int ST_POWERED = 1;
  localparam int ST_RAW_DET = 2;
  localparam int ST_RESET_LVL = 3;
  localparam int ST_SUPPLY_OK = 4;

  // Interrupt status and mask fields
  localparam int IRQ_INSERT = 0;
  localparam int IRQ_REMOVE = 1;
  localparam int IRQ_POWERED = 2;
  localparam int IRQ_FAULT = 3;
  localparam int IRQ_W = 4;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // Timing
  localparam int CLK_MHZ = 100;
  localparam int DEBOUNCE_NS = 1000;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_NS = 500;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;

  // Card power sequence
  typedef enum logic [1:0] {
    CCP_OFF,
    CCP_RAMP,
    CCP_SETTLE,
    CCP_ON
  } ccp_pwr_e;
endpackage : ccp_pkg
`default_nettype wire

// File: rtl/ccp_sync.sv
`default_nettype none
module ccp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic [WIDTH-1:0] d, // Asynchronous levels
  output logic [WIDTH-1:0] q // Synchronised levels
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : ccp_sync
`default_nettype wire

// File: rtl/ccp_filter.sv
`default_nettype none
module ccp_filter #(
  parameter int CYCLES = 100,
  parameter logic INIT = 1'b1
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic d, // Synchronised raw level
  output logic q // Filtered level
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] count;
  wire differs = (d != q);
  wire done = differs && (count == LAST);

  // Count run length of a differing level; any bounce restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      q <= INIT;
    end else begin
      count <= (differs && !done) ? count + 1'b1 : '0;
      if (done) begin
        q <= d;
      end
    end
  end
endmodule : ccp_filter
`default_nettype wire

// File: verif/ccp_properties.sv
`default_nettype none
module ccp_properties (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic clock_select_in, // Selector output
  input wire logic supply_ok_in, // Supply good pin
  input wire logic card_clock_out, // Card clock
  input wire logic card_clock_slope_fast, // Slope select
  input wire logic card_presence_pullup_en, // Detect bias
  input wire logic host_reset_in, // Host reset pin
  input wire logic chip_select_n, // Chip select pin
  input wire logic card_reset_out, // Card reset
  input wire logic host_io_out, // Host line value
  input wire logic host_io_oe, // Host line enable
  input wire logic card_serial_line_out, // Card line value
  input wire logic card_serial_line_oe // Card line enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic mapped;
  // Four mapped words; anything else is refused
  assign mapped = paddr inside {ccp_pkg::ADDR_CTRL, ccp_pkg::ADDR_STATUS,
    ccp_pkg::ADDR_IRQ_STAT, ccp_pkg::ADDR_IRQ_MASK};
  // Supply low long enough to pass the synchroniser
  sequence supply_gone;
    !supply_ok_in [*4];
  endsequence
  sequence ctrl_wr;
    psel && penable && pwrite && paddr == ccp_pkg::ADDR_CTRL;
  endsequence
  ////////////////////////////////////////////////////////////
  clk_off_a:
    assert property (supply_gone |-> !card_clock_out)
    else $error("card clock driven without supply");
  clk_source_a:
    assert property (card_clock_out |-> $past(clock_select_in))
    else $error("card clock not from selector");
  slope_follow_a:
    assert property (ctrl_wr |-> ##2 card_clock_slope_fast ==
      $past(pwdata[ccp_pkg::CTRL_SLOPE_FAST], 2))
    else $error("slope select not applied");
  bias_on_a:
    assert property (card_presence_pullup_en)
    else $error("detect bias switched off");
  rst_gate_a:
    assert property ($rose(card_reset_out) |->
      !$past(chip_select_n, 3) && $past(host_reset_in, 3))
    else $error("card reset rose without select");
  rst_off_a:
    assert property (supply_gone |-> !card_reset_out)
    else $error("card reset high without supply");
  io_off_a:
    assert property (supply_gone |-> card_serial_line_oe && !host_io_oe)
    else $error("serial line not held low");
  drive_low_a:
    assert property (!host_io_out && !card_serial_line_out)
    else $error("open drain line driven high");
  apb_err_a:
    assert property (psel && penable |-> pslverr == !mapped)
    else $error("error response wrong");
  apb_ready_a:
    assert property (psel && penable |-> pready)
    else $error("access phase stretched");
endmodule : ccp_properties
`default_nettype wire

// File: verif/ccp_card_model.sv
`default_nettype none
module ccp_card_model (
  input wire logic present, // Card seated
  input wire logic spike, // Short switch bounce
  input wire logic tx_low, // Card pulls its line low
  input wire logic card_presence_pullup_en, // Weak bias on
  input wire logic card_serial_line_oe, // Device pulls line low
  output logic card_presence_in, // Detect pin level
  output logic card_serial_line_in // Serial line level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Switch to ground; an open pin rests on the weak bias only
  // bias high
  assign card_presence_in = (present ^ spike) ? 1'b0 :
    card_presence_pullup_en;
  // Line has a pull-up, so low wins from either side
  // both directions
  assign card_serial_line_in = !(card_serial_line_oe || tx_low);
endmodule : ccp_card_model
`default_nettype wire

// File: verif/ccp_top_tb_top.sv
`default_nettype none
module ccp_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, irq, card_supply_en, card_clock_out;
  logic clock_select_in = 0, supply_ok_in = 0, host_reset_in = 0;
  logic chip_select_n = 1, present = 0, spike = 0, tx_low = 0;
  logic host_low = 0, host_io_in, host_io_out, host_io_oe, b0;
  logic card_clock_slope_fast, card_presence_in, card_presence_pullup_en;
  logic card_reset_out, card_serial_line_in, card_serial_line_out;
  logic card_serial_line_oe;
  logic [32:0] expq[$];
  logic [2:0] rtab[5] = '{3'b110, 3'b011, 3'b101, 3'b000, 3'b011};
  logic [3:0] stab[4] = '{4'b1010, 4'b0000, 4'b0101, 4'b0000};
  int seed = 50615, cycles = 0, mismatches = 0, checks = 0, cnt;

  ccp_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .irq, .clock_select_in, .supply_ok_in,
    .card_supply_en, .card_clock_out, .card_clock_slope_fast,
    .card_presence_in, .card_presence_pullup_en, .host_reset_in,
    .chip_select_n, .card_reset_out, .host_io_in, .host_io_out,
    .host_io_oe, .card_serial_line_in, .card_serial_line_out,
    .card_serial_line_oe);
  ccp_card_model card (.present, .spike, .tx_low, .card_presence_pullup_en,
    .card_serial_line_oe, .card_presence_in, .card_serial_line_in);
  // Host line has a pull-up too
  assign host_io_in = !(host_io_oe || host_low);

  always #5 pclk = ~pclk;
  // Selector output wanders so the clock path is exercised
  always @(posedge pclk) clock_select_in <= 1'($random(seed));
  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end
  // Read answers are matched against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk("prdata", expq.pop_front(), {pslverr, prdata});
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [32:0] e,
    input logic [32:0] s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Idle cycle after each transfer keeps drives one per step
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [32:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d[31:0];
    if (!w) expq.push_back(d);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, ccp_pkg::ADDR_CTRL, 33'h0);
    apb(0, ccp_pkg::ADDR_STATUS, 33'h4);
    apb(0, ccp_pkg::ADDR_IRQ_STAT, 33'h0);
    apb(0, ccp_pkg::ADDR_IRQ_MASK, 33'h0);
    apb(0, 8'h10, 33'h100000000);
    chk("card_reset_out", 0, card_reset_out);
    // Bounce shorter than the filter, then a real insertion
    apb(1, ccp_pkg::ADDR_IRQ_MASK, 33'h3);
    spike <= 1'b1;
    repeat (40) @(posedge pclk);
    spike <= 1'b0;
    repeat (110) @(posedge pclk);
    apb(0, ccp_pkg::ADDR_STATUS, 33'h4);
    present <= 1'b1;
    repeat (60) @(posedge pclk);
    apb(0, ccp_pkg::ADDR_STATUS, 33'h4);
    repeat (60) @(posedge pclk);
    apb(0, ccp_pkg::ADDR_STATUS, 33'h1);
    chk("irq", 1, irq);
    apb(0, ccp_pkg::ADDR_IRQ_STAT, 33'h1);
    apb(1, ccp_pkg::ADDR_IRQ_STAT, 33'h1);
    @(posedge pclk);
    chk("irq", 0, irq);
    // Every polarity and report mode, card out then in
    for (int p = 0; p < 2; p++) begin
      present <= p[0];
      repeat (120) @(posedge pclk);
      for (int m = 0; m < 4; m++) begin
        apb(1, ccp_pkg::ADDR_CTRL, {m[1:0], 2'b00});
        b0 = (m[1] || m[0]) ? !p[0] : p[0];
        apb(0, ccp_pkg::ADDR_STATUS, {30'h0, !p[0], 1'b0, b0});
      end
    end
    // Power up; lines stay low through the settle time
    apb(1, ccp_pkg::ADDR_CTRL, 33'h3);
    // Polarity back to low-active raises an insert; clear it and older ones
    apb(1, ccp_pkg::ADDR_IRQ_STAT, 33'hf);
    cnt = 0;
    while (card_supply_en !== 1'b1 && cnt < 20) begin
      @(posedge pclk);
      cnt++;
    end
    chk("card_supply_en", 1, card_supply_en);
    repeat (1 + ($random(seed) & 15)) @(posedge pclk);
    supply_ok_in <= 1'b1;
    cnt = 0;
    while (card_serial_line_oe !== 1'b0 && cnt < 200) begin
      @(posedge pclk);
      cnt++;
    end
    chk("start-up hold", 1, cnt inside {[50:60]});
    apb(0, ccp_pkg::ADDR_STATUS, 33'h13);
    // Powered clock copies the selector one cycle late
    repeat (8) begin
      b0 = clock_select_in;
      @(posedge pclk);
      chk("card_clock_out", b0, card_clock_out);
    end
    apb(0, ccp_pkg::ADDR_IRQ_STAT, 33'h4);
    chk("irq masked", 0, irq);
    // Chip select gates the forwarded reset
    foreach (rtab[i]) begin
      chip_select_n <= rtab[i][2];
      host_reset_in <= rtab[i][1];
      repeat (6) @(posedge pclk);
      chk("card_reset_out", rtab[i][0], card_reset_out);
    end
    // Card talks, then host talks
    foreach (stab[i]) begin
      {tx_low, host_low} <= stab[i][3:2];
      repeat (8) @(posedge pclk);
      chk("io drive", stab[i][1:0], {host_io_oe, card_serial_line_oe});
    end
    // Supply lost while active
    supply_ok_in <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("pins off", 3'b010,
      {card_clock_out, card_serial_line_oe, card_reset_out});
    apb(0, ccp_pkg::ADDR_IRQ_STAT, 33'hc);
    apb(0, ccp_pkg::ADDR_STATUS, 33'h1);
    apb(1, ccp_pkg::ADDR_CTRL, 33'h0);
    final_report();
  end
endmodule : ccp_top_tb_top

bind ccp_top ccp_properties u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .clock_select_in,
  .supply_ok_in, .card_clock_out, .card_clock_slope_fast,
  .card_presence_pullup_en, .host_reset_in, .chip_select_n,
  .card_reset_out, .host_io_out, .host_io_oe, .card_serial_line_out,
  .card_serial_line_oe);
`default_nettype wire
